// [logic/tmhp_top.sv]
// Test-access-port master: strobed byte host port and serial test bus driver.
// Assumes host pins are synchronous to clk; the bench reads each output and its enable as separate signals.
`timescale 1ns/1ps
// How it works
// - Three-bit index selects one of eight registers
// - Eight-bit data bus, bit seven most significant
// - Ready stays high unless access is blocked
// - Ready rises once blocking condition clears
// - Strobe rising edge returns ready high
// - Low reset asynchronously holds device in reset
// - Reset: ignore writes, outputs high, clock/16
// - Read-not-write high reads, low writes
// - Drive data only on read with strobe low
// - Strobe falling starts, rising ends an access
// - Normal test clock from programmable divider
// - Discrete read raises clock, write lowers it
// - Sample returning data on clock rising edge
// - Everything else clocked by system clock
// - Data and mode change on clock falling edge
// - Test outputs released while output enable high
// - Target reset low only by host write
module tmhp_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] registerIndex,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOe,
  input wire logic readNotWrite,
  input wire logic accessStrobeN,
  output logic ready,
  output logic tck,
  output logic tckOe,
  output logic tdo,
  output logic tdoOe,
  output logic tms,
  output logic tmsOe,
  output logic trstN,
  output logic trstOe,
  input wire logic tdi,
  input wire logic tapOutputEnableN
);
  import tmhp_pkg::*;

  tmhp_tck_if tckIf ();

  // ----------------------------------------
  // Host access tracking
  // ----------------------------------------
  logic strobePrev_reg;
  logic active_reg;
  logic done_reg;
  logic blocked;
  logic doAccess;
  logic doWrite;
  logic doRead;
  logic [7:0] mode_reg;
  logic [7:0] divisor_reg;
  logic [7:0] discrete_reg;
  logic [7:0] txShift_reg;
  logic [7:0] rxShift_reg;
  logic [7:0] rxData_reg;
  logic [3:0] bitCnt_reg;
  logic busy_reg;
  logic tdo_reg;
  logic tms_reg;
  logic trstN_reg;
  logic [7:0] readMux;
  logic discreteMode;
  logic strobeFell;
  logic strobeRose;
  logic armed_reg;
  logic loadTx;
  logic shiftRise;
  logic shiftFall;
  logic lastRise;

  assign discreteMode = mode_reg[MODE_DISCRETE_BIT];

  assign strobeFell = strobePrev_reg && !accessStrobeN;
  assign strobeRose = !strobePrev_reg && accessStrobeN;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobePrev_reg <= 1'b1;
    end else begin
      strobePrev_reg <= accessStrobeN;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_reg <= 1'b0;
    end else if (strobeFell) begin
      active_reg <= 1'b1;
    end else if (strobeRose) begin
      active_reg <= 1'b0;
    end
  end

  // One access performs once, however long the host holds the strobe low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_reg <= 1'b0;
    end else if (strobeFell || strobeRose) begin
      done_reg <= 1'b0;
    end else if (doAccess) begin
      done_reg <= 1'b1;
    end
  end

  // Only the data byte registers can stall, while the shifter still holds a byte
  always_comb begin
    blocked = 1'b0;
    if (busy_reg && registerIndex == IDX_TX_DATA && !readNotWrite) begin
      blocked = 1'b1;
    end else if (busy_reg && registerIndex == IDX_RX_DATA && readNotWrite) begin
      blocked = 1'b1;
    end
  end

  // Combinational so ready can fall in the first cycle of a blocked access
  assign ready = !(active_reg && !accessStrobeN && blocked);
  assign doAccess = active_reg && !accessStrobeN && !blocked && !done_reg;
  assign doWrite = doAccess && !readNotWrite;
  assign doRead = doAccess && readNotWrite;

  // ----------------------------------------
  // Host register writes
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= MODE_RESET;
    end else if (doWrite && registerIndex == IDX_MODE) begin
      mode_reg <= hostDataIn;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divisor_reg <= DIVISOR_RESET;
    end else if (doWrite && registerIndex == IDX_DIVISOR) begin
      divisor_reg <= hostDataIn;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      discrete_reg <= DISCRETE_RESET;
    end else if (doWrite && registerIndex == IDX_DISCRETE) begin
      discrete_reg <= hostDataIn;
    end
  end

  // ----------------------------------------
  // Host read data
  // ----------------------------------------
  always_comb begin
    case (registerIndex)
      IDX_MODE: readMux = mode_reg;
      IDX_DIVISOR: readMux = divisor_reg;
      IDX_COMMAND: readMux = {7'h00, ~trstN_reg};
      IDX_DISCRETE: readMux = discrete_reg;
      IDX_TX_DATA: readMux = txShift_reg;
      IDX_RX_DATA: readMux = rxData_reg;
      IDX_STATUS: readMux = {5'h00, tdi, tckIf.tck, busy_reg};
      IDX_ID: readMux = ID_VALUE;
      default: readMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hostDataOut <= 8'h00;
    end else if (doRead) begin
      hostDataOut <= readMux;
    end
  end

  assign hostDataOe = readNotWrite && !accessStrobeN;

  // ----------------------------------------
  // Byte shifter on the serial test bus
  // ----------------------------------------
  // Bits go out least significant first; the returning byte fills from the top
  // The free-running clock may rise before bit zero is on the pin, so the first
  // falling edge after a load only arms the shifter and rises before it are not counted
  assign loadTx = doWrite && registerIndex == IDX_TX_DATA && !discreteMode;
  assign shiftRise = busy_reg && armed_reg && tckIf.tckRise;
  assign shiftFall = busy_reg && armed_reg && tckIf.tckFall;
  assign lastRise = shiftRise && (bitCnt_reg + 4'h1 == SHIFT_BITS);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
    end else if (loadTx) begin
      busy_reg <= 1'b1;
    end else if (lastRise) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_reg <= 1'b0;
    end else if (loadTx) begin
      armed_reg <= 1'b0;
    end else if (busy_reg && tckIf.tckFall) begin
      armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_reg <= 4'h0;
    end else if (loadTx) begin
      bitCnt_reg <= 4'h0;
    end else if (shiftRise) begin
      bitCnt_reg <= bitCnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txShift_reg <= 8'h00;
    end else if (loadTx) begin
      txShift_reg <= hostDataIn;
    end else if (shiftFall) begin
      txShift_reg <= {1'b0, txShift_reg[7:1]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxShift_reg <= 8'h00;
      rxData_reg <= 8'h00;
    end else if (shiftRise) begin
      rxShift_reg <= {tdi, rxShift_reg[7:1]};
      if (lastRise) begin
        rxData_reg <= {tdi, rxShift_reg[7:1]};
      end
    end
  end

  // ----------------------------------------
  // Test data, mode select and target reset
  // ----------------------------------------
  // Each later fall presents the bit that the same edge shifts down
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo_reg <= 1'b1;
    end else if (tckIf.tckFall) begin
      if (discreteMode) begin
        tdo_reg <= discrete_reg[DISC_TDO_BIT];
      end else if (busy_reg) begin
        tdo_reg <= armed_reg ? txShift_reg[1] : txShift_reg[0];
      end else begin
        tdo_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tms_reg <= 1'b1;
    end else if (tckIf.tckFall) begin
      if (discreteMode) begin
        tms_reg <= discrete_reg[DISC_TMS_BIT];
      end else begin
        tms_reg <= mode_reg[MODE_TMS_BIT];
      end
    end
  end

  // Target reset follows host writes only, never the shifter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trstN_reg <= 1'b1;
    end else if (doWrite && registerIndex == IDX_COMMAND) begin
      trstN_reg <= ~hostDataIn[CMD_TRST_BIT];
    end else if (doWrite && registerIndex == IDX_DISCRETE && discreteMode) begin
      trstN_reg <= hostDataIn[DISC_TRST_N_BIT];
    end
  end

  // ----------------------------------------
  // Test clock generator
  // ----------------------------------------
  assign tckIf.divisor = divisor_reg;
  assign tckIf.discrete = discreteMode;
  assign tckIf.discRise = doRead && registerIndex == IDX_DISCRETE;
  assign tckIf.discFall = doWrite && registerIndex == IDX_DISCRETE;

  tmhp_tck_gen tckGen (
    .clk(clk),
    .rst_b(rst_b),
    .tckIf(tckIf)
  );

  // ----------------------------------------
  // Test bus pins
  // ----------------------------------------
  // Reset forces levels on the pins even while a transfer was under way
  assign tck = tckIf.tck;
  assign tdo = rst_b ? tdo_reg : 1'b1;
  assign tms = rst_b ? tms_reg : 1'b1;
  assign trstN = rst_b ? trstN_reg : 1'b1;
  assign tckOe = ~tapOutputEnableN;
  assign tdoOe = ~tapOutputEnableN;
  assign tmsOe = ~tapOutputEnableN;
  assign trstOe = ~tapOutputEnableN;
endmodule

// [logic/tmhp_pkg.sv]
// Constants shared by the test-access-port master and its clock generator.
// Assumes one system clock; all host pins are already synchronous to it.
package tmhp_pkg;
  // ----------------------------------------
  // Host register map
  // ----------------------------------------
  localparam logic [2:0] IDX_MODE = 3'h0;
  localparam logic [2:0] IDX_DIVISOR = 3'h1;
  localparam logic [2:0] IDX_COMMAND = 3'h2;
  localparam logic [2:0] IDX_DISCRETE = 3'h3;
  localparam logic [2:0] IDX_TX_DATA = 3'h4;
  localparam logic [2:0] IDX_RX_DATA = 3'h5;
  localparam logic [2:0] IDX_STATUS = 3'h6;
  localparam logic [2:0] IDX_ID = 3'h7;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MODE_DISCRETE_BIT = 0;
  localparam int MODE_TMS_BIT = 1;
  localparam int CMD_TRST_BIT = 0;
  localparam int DISC_TMS_BIT = 0;
  localparam int DISC_TDO_BIT = 1;
  localparam int DISC_TRST_N_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TCK_BIT = 1;
  localparam int STAT_TDI_BIT = 2;
  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h02;
  localparam logic [7:0] DIVISOR_RESET = 8'h07;
  localparam logic [7:0] DISCRETE_RESET = 8'h07;
  localparam logic [7:0] ID_VALUE = 8'h5a;  // Arbitrary value
  localparam int RESET_TCK_DIVIDE = 16;
  localparam int PRESCALE_WIDTH = $clog2(RESET_TCK_DIVIDE);
  localparam logic [3:0] SHIFT_BITS = 4'h8;
endpackage

// [logic/tmhp_tck_if.sv]
// Bundle between the core and its test clock generator.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface tmhp_tck_if;
  logic [7:0] divisor;
  logic discrete;
  logic discRise;
  logic discFall;
  logic tck;
  logic tckRise;
  logic tckFall;
  modport gen (
    input divisor,
    input discrete,
    input discRise,
    input discFall,
    output tck,
    output tckRise,
    output tckFall
  );
  modport core (
    output divisor,
    output discrete,
    output discRise,
    output discFall,
    input tck,
    input tckRise,
    input tckFall
  );
endinterface

// [logic/tmhp_tck_gen.sv]
// Test clock generator: reset divider, programmable divider, discrete edges.
// Assumes clk is the system clock and rst_b the asynchronous active-low reset.
`timescale 1ns/1ps
module tmhp_tck_gen (
  input wire logic clk,
  input wire logic rst_b,
  tmhp_tck_if.gen tckIf
);
  import tmhp_pkg::*;
  // ----------------------------------------
  // Free-running prescaler
  // ----------------------------------------
  // No reset here, so the reset clock keeps running while rst_b is low
  logic [PRESCALE_WIDTH-1:0] preCnt_reg = '0;
  logic [7:0] divCnt_reg;
  logic tck_reg;
  logic tck_next;

  always_ff @(posedge clk) begin
    preCnt_reg <= preCnt_reg + 1'b1;
  end

  // ----------------------------------------
  // Programmable divider and discrete edges
  // ----------------------------------------
  always_comb begin
    tck_next = tck_reg;
    if (tckIf.discrete) begin
      if (tckIf.discRise) begin
        tck_next = 1'b1;
      end else if (tckIf.discFall) begin
        tck_next = 1'b0;
      end
    end else if (divCnt_reg >= tckIf.divisor) begin
      // A divisor lowered mid-count takes effect at once instead of wrapping the counter
      tck_next = ~tck_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_reg <= 8'h00;
      tck_reg <= 1'b0;
    end else begin
      tck_reg <= tck_next;
      if (tckIf.discrete || divCnt_reg >= tckIf.divisor) begin
        divCnt_reg <= 8'h00;
      end else begin
        divCnt_reg <= divCnt_reg + 8'h01;
      end
    end
  end

  // Clock divided by sixteen while held in reset
  assign tckIf.tck = rst_b ? tck_reg : preCnt_reg[PRESCALE_WIDTH-1];
  assign tckIf.tckRise = rst_b & ~tck_reg & tck_next;
  assign tckIf.tckFall = rst_b & tck_reg & ~tck_next;
endmodule

// [verification/tmhp_top_props.sv]
// Pin-level checks for the test-access-port master.
// Assumes it is bound to tmhp_top and sees only its ports.
`timescale 1ns/1ps
module tmhp_top_props (
  input logic clk,
  input logic rst_b,
  input logic accessStrobeN,
  input logic readNotWrite,
  input logic tapOutputEnableN,
  input logic hostDataOe,
  input logic ready,
  input logic tck,
  input logic tckOe,
  input logic tdo,
  input logic tdoOe,
  input logic tms,
  input logic tmsOe,
  input logic trstN,
  input logic trstOe
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  data_drive_a: assert property (hostDataOe == (readNotWrite && !accessStrobeN))
    else $error("data bus enable wrong");
  tap_release_a: assert property ({tckOe, tdoOe, tmsOe, trstOe} == {4{!tapOutputEnableN}})
    else $error("test pin enables wrong");
  ready_idle_a: assert property (accessStrobeN |-> ready)
    else $error("ready low outside an access");
  ready_return_a: assert property ($fell(ready) |-> ##[1:1000] ready)
    else $error("ready stuck low");
  // Reset checks must run while reset is held, so they carry no disable
  reset_levels_a: assert property (disable iff (1'b0) !rst_b |-> ready && tdo && tms && trstN)
    else $error("outputs not high in reset");
  reset_div_a: assert property (disable iff (1'b0) !rst_b && !$past(rst_b) && $changed(tck) |->
    ##1 ($stable(tck) || rst_b) [*7] ##1 ($changed(tck) || rst_b))
    else $error("reset test clock not divided by sixteen");
  tdo_edge_a: assert property ($changed(tdo) || $changed(tms) |-> !tck)
    else $error("serial output moved off falling edge");
  trst_cause_a: assert property ($fell(trstN) |->
    (!$past(readNotWrite) && !$past(accessStrobeN))
    || (!$past(readNotWrite, 2) && !$past(accessStrobeN, 2)))
    else $error("target reset without host write");
endmodule
bind tmhp_top tmhp_top_props chk (.clk(clk), .rst_b(rst_b), .accessStrobeN(accessStrobeN),
  .readNotWrite(readNotWrite), .tapOutputEnableN(tapOutputEnableN), .hostDataOe(hostDataOe),
  .ready(ready), .tck(tck), .tckOe(tckOe), .tdo(tdo), .tdoOe(tdoOe), .tms(tms),
  .tmsOe(tmsOe), .trstN(trstN), .trstOe(trstOe));

// [verification/tmhp_target_model.sv]
// Scan target stand-in: a one-bit bypass stage on the test bus.
// Assumes the master owns tck; tdi idles high like a pulled-up line.
`timescale 1ns/1ps
module tmhp_target_model (
  input logic tck,
  input logic tdo,
  output logic tdi
);
  // ----------------------------------------
  // Bypass stage
  // ----------------------------------------
  logic capReg = 1'b1;
  initial tdi = 1'b1;
  always @(posedge tck) capReg <= tdo;
  // Changing on the falling edge gives the master a settled bit at its rise
  always @(negedge tck) tdi <= capReg;
endmodule

// [verification/testbench.sv]
// Self-checking bench for the test-access-port master.
// Assumes one 25 MHz clock and a bypass target on the test bus.
`timescale 1ns/1ps
module testbench;
  import tmhp_pkg::*;
  // ----------------------------------------
  // Stimulus and scenarios
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] idx = 3'h0;
  logic [7:0] din = 8'h00;
  logic rnw = 1'b1;
  logic strbN = 1'b1;
  logic oeN = 1'b0;
  logic [7:0] dout, q;
  logic dataOe, ready, tck, tckOe, tdo, tdoOe, tms, tmsOe, trstN, trstOe, tdi, sawLow;
  int miscompares = 0;
  int nTests = 0;
  int cyc = 0;
  int t0;
  tmhp_top uut (.clk(clk), .rst_b(rst_b), .registerIndex(idx), .hostDataIn(din),
    .hostDataOut(dout), .hostDataOe(dataOe), .readNotWrite(rnw), .accessStrobeN(strbN),
    .ready(ready), .tck(tck), .tckOe(tckOe), .tdo(tdo), .tdoOe(tdoOe), .tms(tms),
    .tmsOe(tmsOe), .trstN(trstN), .trstOe(trstOe), .tdi(tdi), .tapOutputEnableN(oeN));
  tmhp_target_model target (.tck(tck), .tdo(tdo), .tdi(tdi));
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobe stays low at least five cycles so a held-off access still completes
  task automatic acc(input logic [2:0] i, input logic r, input logic [7:0] d);
    int n;
    n = 0;
    sawLow = 1'b0;
    @(posedge clk);
    idx <= i;
    rnw <= r;
    din <= d;
    strbN <= 1'b0;
    repeat (2) @(negedge clk);
    while (ready !== 1'b1 && n < 2000) begin
      sawLow = 1'b1;
      @(negedge clk);
      n++;
    end
    chk({7'h00, ready}, 8'h01);
    repeat (3) @(negedge clk);
    q = dout;
    chk({7'h00, dataOe}, {7'h00, r});
    @(posedge clk);
    strbN <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic readIds();
    logic [2:0] ix [4] = '{IDX_MODE, IDX_DIVISOR, IDX_DISCRETE, IDX_ID};
    logic [7:0] ex [4] = '{MODE_RESET, DIVISOR_RESET, DISCRETE_RESET, ID_VALUE};
    for (int k = 0; k < 4; k++) begin
      acc(ix[k], 1'b1, 8'h00);
      chk(q, ex[k]);
    end
  endtask
  task automatic divClock();
    acc(IDX_DIVISOR, 1'b0, 8'h02);
    acc(IDX_DIVISOR, 1'b1, 8'h00);
    chk(q, 8'h02);
    @(posedge tck);
    @(negedge clk);
    t0 = cyc;
    @(posedge tck);
    @(negedge clk);
    chk(8'(cyc - t0), 8'h06);
  endtask
  task automatic shiftByte();
    acc(IDX_TX_DATA, 1'b0, 8'h96);
    acc(IDX_RX_DATA, 1'b1, 8'h00);
    chk({7'h00, sawLow}, 8'h01);
    chk(q, 8'h2d);
  endtask
  task automatic discreteSteps();
    acc(IDX_MODE, 1'b0, 8'h03);
    acc(IDX_DISCRETE, 1'b1, 8'h00);
    chk({7'h00, tck}, 8'h01);
    acc(IDX_DISCRETE, 1'b0, 8'h03);
    chk({5'h00, tck, trstN, tdo}, 8'h01);
    acc(IDX_DISCRETE, 1'b0, 8'h03);
    chk({5'h00, tdo, tms, trstN}, 8'h06);
  endtask
  task automatic enableAndReset();
    oeN <= 1'b1;
    @(negedge clk);
    chk({7'h00, tckOe}, 8'h00);
    @(posedge clk);
    oeN <= 1'b0;
    rst_b <= 1'b0;
    acc(IDX_DIVISOR, 1'b0, 8'h09);
    repeat (16) @(negedge clk);
    chk({4'h0, ready, tdo, tms, trstN}, 8'h0f);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    acc(IDX_DIVISOR, 1'b1, 8'h00);
    chk(q, DIVISOR_RESET);
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    chk({4'h0, ready, tdo, tms, trstN}, 8'h0f);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    readIds();
    divClock();
    shiftByte();
    discreteSteps();
    enableAndReset();
    results();
  end
endmodule
